// ===== design/llpr_pkg.sv
// Purpose: Shared constants and types of the logical layer port router
// Assumes: 64-bit stream beats, 32-bit AXI4-Lite register bus
// Notes:   Offsets are byte addresses inside the logical layer region
`default_nettype none
package llpr_pkg;
  // ----------------------------------------------------------------
  // Header fields and transaction types
  // ----------------------------------------------------------------
  localparam int        FTYPE_LSB   = 52;
  localparam logic [3:0] FT_NREAD   = 4'h2;
  localparam logic [3:0] FT_NWRITE  = 4'h5;
  localparam logic [3:0] FT_SWRITE  = 4'h6;
  localparam logic [3:0] FT_MAINT   = 4'h8;
  localparam logic [3:0] FT_DBELL   = 4'hA;
  localparam logic [3:0] FT_MSG     = 4'hB;
  localparam logic [3:0] FT_RESP    = 4'hD;
  localparam logic [7:0] KEEP_ALL   = 8'hFF;
  // ----------------------------------------------------------------
  // Register map and fabric regions
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL  = 12'h000;
  localparam logic [11:0] REG_STAT  = 12'h004;
  localparam logic [11:0] REG_DROP  = 12'h008;
  localparam logic [1:0]  CTRL_RST  = 2'h3;
  localparam int          CTRL_TXEN = 0;
  localparam int          CTRL_RXEN = 1;
  localparam logic [15:0] DROP_RST  = 16'h0000;
  localparam logic [1:0]  RGN_LOG   = 2'h0;
  localparam logic [1:0]  RGN_PHY   = 2'h1;
  localparam logic [1:0]  RGN_BUF   = 2'h2;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  localparam logic [1:0]  RESP_DEC  = 2'h3;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DST_IO   = 3'b000,
    DST_MSG  = 3'b001,
    DST_MNT  = 3'b010,
    DST_USR  = 3'b011,
    DST_DROP = 3'b100
  } llpr_dest_t;
  typedef enum logic [1:0] {
    CF_IDLE = 2'b00,
    CF_EXT  = 2'b01,
    CF_RESP = 2'b10
  } llpr_cfg_t;
endpackage
`default_nettype wire

// ===== design/llpr_router.sv
// Purpose: Steers packets between user ports and the transport side
// Assumes: One clock; cfg_resetn and aresetn are synchronous to aclk
// Notes:   Rx ports msg/mnt/usr share the iorx data bus, own valid
`default_nettype none
module llpr_router import llpr_pkg::*; #(
  parameter bit MSG_SUPPORT  = 1'b1,
  parameter bit MSG_PORT     = 1'b1,
  parameter bit MNT_PORT     = 1'b1,
  parameter bit USR_PORT     = 1'b1,
  parameter bit MAINT_STREAM = 1'b0,
  parameter bit HDR_FORMAT   = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cfg_resetn,
  input  wire logic [1:0]  link_width,
  output logic       [1:0] clk_rate_sel,
  input  wire logic        s_axis_iotx_tvalid,
  output logic             s_axis_iotx_tready,
  input  wire logic [63:0] s_axis_iotx_tdata,
  input  wire logic [7:0]  s_axis_iotx_tkeep,
  input  wire logic        s_axis_iotx_tlast,
  input  wire logic [31:0] s_axis_iotx_tuser,
  input  wire logic        s_axis_mntx_tvalid,
  output logic             s_axis_mntx_tready,
  input  wire logic [63:0] s_axis_mntx_tdata,
  input  wire logic [7:0]  s_axis_mntx_tkeep,
  input  wire logic        s_axis_mntx_tlast,
  input  wire logic [31:0] s_axis_mntx_tuser,
  output logic             m_axis_ttx_tvalid,
  input  wire logic        m_axis_ttx_tready,
  output logic      [63:0] m_axis_ttx_tdata,
  output logic      [7:0]  m_axis_ttx_tkeep,
  output logic             m_axis_ttx_tlast,
  output logic      [31:0] m_axis_ttx_tuser,
  input  wire logic        s_axis_trx_tvalid,
  output logic             s_axis_trx_tready,
  input  wire logic [63:0] s_axis_trx_tdata,
  input  wire logic [7:0]  s_axis_trx_tkeep,
  input  wire logic        s_axis_trx_tlast,
  input  wire logic [31:0] s_axis_trx_tuser,
  output logic             m_axis_iorx_tvalid,
  input  wire logic        m_axis_iorx_tready,
  output logic             m_axis_msgrx_tvalid,
  input  wire logic        m_axis_msgrx_tready,
  output logic             m_axis_mntrx_tvalid,
  input  wire logic        m_axis_mntrx_tready,
  output logic             m_axis_usrrx_tvalid,
  input  wire logic        m_axis_usrrx_tready,
  output logic      [63:0] m_axis_iorx_tdata,
  output logic      [7:0]  m_axis_iorx_tkeep,
  output logic             m_axis_iorx_tlast,
  output logic      [31:0] m_axis_iorx_tuser,
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             ext_cfg_req,
  output logic             ext_cfg_wr,
  output logic      [1:0]  ext_cfg_sel,
  output logic      [11:0] ext_cfg_addr,
  output logic      [31:0] ext_cfg_wdata,
  output logic      [3:0]  ext_cfg_wstrb,
  input  wire logic        ext_cfg_ack,
  input  wire logic [31:0] ext_cfg_rdata
);
  // ----------------------------------------------------------------
  // Routing decision
  // ----------------------------------------------------------------
  function automatic llpr_dest_t route(input logic [3:0] ft);
    llpr_dest_t d;
    d = USR_PORT ? DST_USR : DST_DROP;
    if (ft == FT_NREAD || ft == FT_NWRITE || ft == FT_SWRITE ||
        ft == FT_RESP || ft == FT_DBELL) begin
      d = DST_IO;
    end else if (ft == FT_MSG && MSG_SUPPORT) begin
      d = MSG_PORT ? DST_MSG : DST_IO;
    end else if (ft == FT_MAINT && MNT_PORT) begin
      d = DST_MNT;
    end
    return d;
  endfunction

  logic [1:0]  ctrl;
  logic [15:0] drop_cnt;
  logic [1:0]  width_m;
  logic [1:0]  width_s;
  logic        rate_done;
  logic        rx_v;
  llpr_dest_t  rx_dest;
  llpr_dest_t  rx_cur;
  llpr_dest_t  rx_bdest;
  logic        rx_first;
  logic        rx_oready;
  logic        rx_take;
  logic        tx_v;
  logic        tx_busy;
  logic        tx_mnt;
  logic        tx_sel_mnt;
  logic        tx_drop;
  logic        tx_bdrop;
  logic        tx_room;
  logic        tx_take;

  // ----------------------------------------------------------------
  // Link width synchroniser and clock rate hold
  // ----------------------------------------------------------------
  // Rate is caught once after reset; train-down leaves it alone
  always_ff @(posedge aclk) begin
    width_m <= link_width;
    width_s <= width_m;
    if (!aresetn) begin
      rate_done    <= 1'b0;
      clk_rate_sel <= 2'h0;
    end else if (!rate_done) begin
      rate_done    <= 1'b1;
      clk_rate_sel <= width_s;
    end
  end

  // ----------------------------------------------------------------
  // Receive path: one register stage, route on first beat
  // ----------------------------------------------------------------
  always_comb begin
    rx_bdest = rx_first ? route(s_axis_trx_tdata[FTYPE_LSB +: 4]) : rx_cur;
    case (rx_dest)
      DST_IO:  rx_oready = m_axis_iorx_tready;
      DST_MSG: rx_oready = m_axis_msgrx_tready;
      DST_MNT: rx_oready = m_axis_mntrx_tready;
      default: rx_oready = m_axis_usrrx_tready;
    endcase
  end
  assign s_axis_trx_tready = ctrl[CTRL_RXEN] && (!rx_v || rx_oready);
  assign rx_take = s_axis_trx_tvalid && s_axis_trx_tready;

  // Stage load; dropped beats are taken and never shown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_v     <= 1'b0;
      rx_first <= 1'b1;
      rx_cur   <= DST_IO;
      rx_dest  <= DST_IO;
    end else if (rx_take) begin
      rx_v     <= (rx_bdest != DST_DROP);
      rx_first <= s_axis_trx_tlast;
      rx_cur   <= rx_bdest;
      rx_dest  <= rx_bdest;
    end else if (rx_oready) begin
      rx_v <= 1'b0;
    end
  end

  // Receive data held in flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_axis_iorx_tdata <= 64'h0;
      m_axis_iorx_tkeep <= 8'h0;
      m_axis_iorx_tlast <= 1'b0;
      m_axis_iorx_tuser <= 32'h0;
    end else if (rx_take) begin
      m_axis_iorx_tdata <= s_axis_trx_tdata;
      m_axis_iorx_tkeep <= HDR_FORMAT ? KEEP_ALL : s_axis_trx_tkeep;
      m_axis_iorx_tlast <= s_axis_trx_tlast;
      m_axis_iorx_tuser <= s_axis_trx_tuser;
    end
  end
  assign m_axis_iorx_tvalid  = rx_v && rx_dest == DST_IO;
  assign m_axis_msgrx_tvalid = rx_v && rx_dest == DST_MSG;
  assign m_axis_mntrx_tvalid = rx_v && rx_dest == DST_MNT;
  assign m_axis_usrrx_tvalid = rx_v && rx_dest == DST_USR;

  // ----------------------------------------------------------------
  // Transmit path: packet-locked merge of I/O and maintenance
  // ----------------------------------------------------------------
  assign tx_room    = ctrl[CTRL_TXEN] && (!tx_v || m_axis_ttx_tready);
  assign tx_sel_mnt = tx_busy ? tx_mnt : (MNT_PORT && s_axis_mntx_tvalid);
  assign s_axis_iotx_tready = tx_room && !tx_sel_mnt;
  assign s_axis_mntx_tready = tx_room && tx_sel_mnt;
  assign tx_take = tx_sel_mnt ? s_axis_mntx_tvalid && s_axis_mntx_tready
                              : s_axis_iotx_tvalid && s_axis_iotx_tready;
  // Maintenance on the I/O channel is discarded while the port exists
  assign tx_bdrop = !tx_sel_mnt && (tx_busy ? tx_drop :
                    MNT_PORT && s_axis_iotx_tdata[FTYPE_LSB +: 4] == FT_MAINT);

  // Packet lock and stage valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_v    <= 1'b0;
      tx_busy <= 1'b0;
      tx_mnt  <= 1'b0;
      tx_drop <= 1'b0;
    end else if (tx_take) begin
      tx_v    <= !tx_bdrop;
      tx_busy <= !(tx_sel_mnt ? s_axis_mntx_tlast : s_axis_iotx_tlast);
      tx_mnt  <= tx_sel_mnt;
      tx_drop <= tx_bdrop;
    end else if (m_axis_ttx_tready) begin
      tx_v <= 1'b0;
    end
  end

  // Transmit data held in flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_axis_ttx_tdata <= 64'h0;
      m_axis_ttx_tkeep <= 8'h0;
      m_axis_ttx_tlast <= 1'b0;
      m_axis_ttx_tuser <= 32'h0;
    end else if (tx_take) begin
      m_axis_ttx_tdata <= tx_sel_mnt ? s_axis_mntx_tdata : s_axis_iotx_tdata;
      m_axis_ttx_tkeep <= tx_sel_mnt ? s_axis_mntx_tkeep : s_axis_iotx_tkeep;
      m_axis_ttx_tlast <= tx_sel_mnt ? s_axis_mntx_tlast : s_axis_iotx_tlast;
      m_axis_ttx_tuser <= tx_sel_mnt ? s_axis_mntx_tuser : s_axis_iotx_tuser;
    end
  end
  assign m_axis_ttx_tvalid = tx_v;

  // ----------------------------------------------------------------
  // Configuration master and fabric over AXI4-Lite
  // ----------------------------------------------------------------
  llpr_cfg_t   cf_state;
  logic        aw_full;
  logic        w_full;
  logic        ar_full;
  logic        op_wr;
  logic [13:0] aw_addr;
  logic [13:0] ar_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [13:0] op_addr;
  logic        drop_ev;
  logic        drop_clr;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready  = !w_full;
  assign s_axi_arready = !ar_full;
  assign s_axi_bvalid  = cf_state == CF_RESP && op_wr;
  assign s_axi_rvalid  = cf_state == CF_RESP && !op_wr;
  assign op_addr       = (aw_full && w_full) ? aw_addr : ar_addr;

  // Address, data and read request holds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      ar_full <= 1'b0;
      aw_addr <= 14'h0;
      ar_addr <= 14'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_full <= 1'b0;
      end
      if (s_axi_arvalid && !ar_full) begin
        ar_full <= 1'b1;
        ar_addr <= s_axi_araddr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        ar_full <= 1'b0;
      end
    end
  end

  // Fabric decode: log region local, phy and buf forwarded only while MAINT_STREAM is clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cf_state      <= CF_IDLE;
      op_wr         <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      s_axi_rresp   <= RESP_OK;
      s_axi_rdata   <= 32'h0;
      ext_cfg_req   <= 1'b0;
      ext_cfg_wr    <= 1'b0;
      ext_cfg_sel   <= RGN_LOG;
      ext_cfg_addr  <= 12'h0;
      ext_cfg_wdata <= 32'h0;
      ext_cfg_wstrb <= 4'h0;
    end else begin
      case (cf_state)
        CF_IDLE: begin
          if ((aw_full && w_full) || ar_full) begin
            op_wr       <= aw_full && w_full;
            s_axi_bresp <= RESP_OK;
            s_axi_rresp <= RESP_OK;
            s_axi_rdata <= 32'h0;
            cf_state    <= CF_RESP;
            if (op_addr[13:12] == RGN_LOG) begin
              if (op_addr[11:0] == REG_CTRL) begin
                s_axi_rdata <= {30'h0, ctrl};
              end else if (op_addr[11:0] == REG_STAT) begin
                s_axi_rdata <= {24'h0, tx_busy, !rx_first, clk_rate_sel, 2'h0, width_s};
                s_axi_bresp <= RESP_SLV;
              end else if (op_addr[11:0] == REG_DROP) begin
                s_axi_rdata <= {16'h0, drop_cnt};
              end else begin
                s_axi_bresp <= RESP_SLV;
                s_axi_rresp <= RESP_SLV;
              end
            end else if (op_addr[13:12] != 2'h3 && !MAINT_STREAM) begin
              ext_cfg_req   <= 1'b1;
              ext_cfg_wr    <= aw_full && w_full;
              ext_cfg_sel   <= op_addr[13:12];
              ext_cfg_addr  <= op_addr[11:0];
              ext_cfg_wdata <= w_data;
              ext_cfg_wstrb <= w_strb;
              cf_state      <= CF_EXT;
            end else begin
              s_axi_bresp <= RESP_DEC;
              s_axi_rresp <= RESP_DEC;
            end
          end
        end
        CF_EXT: begin
          if (ext_cfg_ack) begin
            ext_cfg_req <= 1'b0;
            s_axi_rdata <= ext_cfg_rdata;
            cf_state    <= CF_RESP;
          end
        end
        CF_RESP: begin
          if ((op_wr && s_axi_bready) || (!op_wr && s_axi_rready)) begin
            cf_state <= CF_IDLE;
          end
        end
        default: cf_state <= CF_IDLE;
      endcase
    end
  end

  // Local registers; config reset returns them to defaults
  assign drop_ev  = rx_take && rx_bdest == DST_DROP && rx_first;
  assign drop_clr = cf_state == CF_IDLE && aw_full && w_full &&
                    aw_addr == {RGN_LOG, REG_DROP};
  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg_resetn) begin
      ctrl     <= CTRL_RST;
      drop_cnt <= DROP_RST;
    end else begin
      if (cf_state == CF_IDLE && aw_full && w_full &&
          aw_addr == {RGN_LOG, REG_CTRL} && w_strb[0]) begin
        ctrl <= w_data[1:0];
      end
      if (drop_ev) begin
        drop_cnt <= drop_clr ? 16'h1 : drop_cnt + 16'h1;
      end else if (drop_clr) begin
        drop_cnt <= DROP_RST;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  dbell_io_a: assert property (rx_take && rx_first && rx_bdest != DST_DROP &&
    s_axis_trx_tdata[FTYPE_LSB +: 4] == FT_DBELL |=> m_axis_iorx_tvalid)
    else $error("doorbell not on io port");
  mnt_rx_a: assert property (rx_take && rx_first && MNT_PORT &&
    s_axis_trx_tdata[FTYPE_LSB +: 4] == FT_MAINT |=> m_axis_mntrx_tvalid)
    else $error("maintenance not on maintenance port");
  usr_drop_a: assert property (rx_take && rx_bdest == DST_DROP |=> !rx_v)
    else $error("dropped packet shown");
  rx_keep_a: assert property (HDR_FORMAT && rx_v |-> m_axis_iorx_tkeep == KEEP_ALL)
    else $error("keep not all ones");
  tx_pass_a: assert property (s_axis_iotx_tvalid && s_axis_iotx_tready && !tx_bdrop
    |=> m_axis_ttx_tvalid && m_axis_ttx_tdata == $past(s_axis_iotx_tdata))
    else $error("tx beat lost");
  tx_ready_a: assert property (s_axis_iotx_tready |-> ctrl[CTRL_TXEN] &&
    (!m_axis_ttx_tvalid || m_axis_ttx_tready))
    else $error("ready without room");
  rate_hold_a: assert property (rate_done |=> $stable(clk_rate_sel))
    else $error("clock rate changed");
  cfg_rst_a: assert property (!cfg_resetn |=> ctrl == CTRL_RST && drop_cnt == DROP_RST)
    else $error("config reset missed");
  fab_fwd_a: assert property (cf_state == CF_IDLE && !(aw_full && w_full) && ar_full &&
    ar_addr[13:12] == RGN_PHY && !MAINT_STREAM |=> ext_cfg_req ##0
    ext_cfg_sel == RGN_PHY)
    else $error("phy access not forwarded");
  tx_last_c: cover property (m_axis_ttx_tvalid && m_axis_ttx_tready && m_axis_ttx_tlast);
  rx_msg_c: cover property (m_axis_msgrx_tvalid && m_axis_msgrx_tready);
  ext_wr_c: cover property (ext_cfg_req && ext_cfg_wr && ext_cfg_ack);
  drop_c: cover property (drop_ev);
endmodule
`default_nettype wire

// ===== verif/llpr_user_model.sv
// Purpose: Stream source standing in for user logic or the transport side
// Assumes: Beat k of a packet carries the start word plus k
// Notes:   Idle data toggles every cycle so a stale beat never looks held
`default_nettype none
module llpr_user_model import llpr_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic [63:0] word,
  input  wire logic [3:0]  beats,
  input  wire logic        tready,
  output logic             busy,
  output logic             tvalid,
  output logic      [63:0] tdata,
  output logic      [7:0]  tkeep,
  output logic             tlast,
  output logic      [31:0] tuser
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left;
  // ----------------------------------------------------------------
  // Packet sequencer
  // ----------------------------------------------------------------
  // Offer a packet, hold each beat until taken, flag the final beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy   <= 1'b0;
      tvalid <= 1'b0;
      tlast  <= 1'b0;
      tdata  <= 64'h0;
      left   <= 4'h0;
    end else if (start && !busy) begin
      busy   <= 1'b1;
      tvalid <= 1'b1;
      tdata  <= word;
      left   <= beats - 4'h1;
      tlast  <= (beats == 4'h1);
    end else if (tvalid && tready) begin
      tvalid <= !tlast;
      busy   <= !tlast;
      tlast  <= !tlast && (left == 4'h1);
      left   <= left - 4'h1;
      tdata  <= tlast ? ~tdata : tdata + 64'h1;
    end else if (!tvalid) begin
      tdata  <= ~tdata;
    end
  end
  // Header format keeps every byte qualified
  assign tkeep = KEEP_ALL;
  assign tuser = tdata[63:32];
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the logical layer port router
// Assumes: Default generation parameters, one clock for both resets
// Notes:   Queues predict each routed beat; sinks stall at random
`default_nettype none
module tb_top import llpr_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn, cfg_resetn, s_axis_iotx_tvalid, s_axis_iotx_tready,
    s_axis_iotx_tlast, s_axis_mntx_tvalid, s_axis_mntx_tready, s_axis_mntx_tlast,
    m_axis_ttx_tvalid, m_axis_ttx_tready, m_axis_ttx_tlast, s_axis_trx_tvalid,
    s_axis_trx_tready, s_axis_trx_tlast, m_axis_iorx_tvalid, m_axis_iorx_tready,
    m_axis_msgrx_tvalid, m_axis_msgrx_tready, m_axis_mntrx_tvalid, m_axis_mntrx_tready,
    m_axis_usrrx_tvalid, m_axis_usrrx_tready, m_axis_iorx_tlast, s_axi_awvalid,
    s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    s_axi_arready, s_axi_rvalid, s_axi_rready, ext_cfg_req, ext_cfg_wr, ext_cfg_ack;
  logic [1:0]  link_width, clk_rate_sel, s_axi_bresp, s_axi_rresp, ext_cfg_sel;
  logic [50:0] exp_ext;
  logic [63:0] s_axis_iotx_tdata, s_axis_mntx_tdata, m_axis_ttx_tdata, s_axis_trx_tdata,
    m_axis_iorx_tdata;
  logic [7:0]  s_axis_iotx_tkeep, s_axis_mntx_tkeep, m_axis_ttx_tkeep, s_axis_trx_tkeep,
    m_axis_iorx_tkeep;
  logic [31:0] s_axis_iotx_tuser, s_axis_mntx_tuser, m_axis_ttx_tuser, s_axis_trx_tuser,
    m_axis_iorx_tuser, s_axi_wdata, s_axi_rdata, ext_cfg_wdata, ext_cfg_rdata;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [11:0] ext_cfg_addr;
  logic [3:0]  s_axi_wstrb, ext_cfg_wstrb;
  logic [2:0]  st, busy;
  logic [63:0] wd [3];
  logic [3:0]  bt [3];
  logic [3:0]  io_ft [5] = '{FT_NREAD, FT_NWRITE, FT_SWRITE, FT_DBELL, FT_RESP};
  logic [66:0] txq [$];
  logic [66:0] rxq [$];
  logic [66:0] et, er;
  logic [3:0]  rxh;
  logic [1:0]  rxp;
  integer      seed = 32'hC6EDF068;
  int          fails = 0;
  int          total_checks = 0;
  localparam logic [31:0] EXT_WORD = 32'h5AC30F96;
  // ----------------------------------------------------------------
  // Design, sources and far-side responders
  // ----------------------------------------------------------------
  llpr_router uut (.*);
  llpr_user_model src_io (.aclk, .aresetn, .start(st[0]), .word(wd[0]), .beats(bt[0]),
    .busy(busy[0]), .tvalid(s_axis_iotx_tvalid), .tready(s_axis_iotx_tready),
    .tdata(s_axis_iotx_tdata), .tkeep(s_axis_iotx_tkeep), .tlast(s_axis_iotx_tlast),
    .tuser(s_axis_iotx_tuser));
  llpr_user_model src_mn (.aclk, .aresetn, .start(st[1]), .word(wd[1]), .beats(bt[1]),
    .busy(busy[1]), .tvalid(s_axis_mntx_tvalid), .tready(s_axis_mntx_tready),
    .tdata(s_axis_mntx_tdata), .tkeep(s_axis_mntx_tkeep), .tlast(s_axis_mntx_tlast),
    .tuser(s_axis_mntx_tuser));
  llpr_user_model src_rx (.aclk, .aresetn, .start(st[2]), .word(wd[2]), .beats(bt[2]),
    .busy(busy[2]), .tvalid(s_axis_trx_tvalid), .tready(s_axis_trx_tready),
    .tdata(s_axis_trx_tdata), .tkeep(s_axis_trx_tkeep), .tlast(s_axis_trx_tlast),
    .tuser(s_axis_trx_tuser));
  // Clock at 50 MHz
  always #10 aclk = ~aclk;
  // Sinks stall at random
  always @(posedge aclk) begin
    {m_axis_ttx_tready, m_axis_iorx_tready, m_axis_msgrx_tready, m_axis_mntrx_tready,
      m_axis_usrrx_tready} <= 5'($random(seed));
  end
  // Far register port answers each request once; idle data toggles
  always @(posedge aclk) begin
    ext_cfg_ack <= aresetn && ext_cfg_req && !ext_cfg_ack;
    ext_cfg_rdata <= (ext_cfg_req && !ext_cfg_ack) ? EXT_WORD : ~ext_cfg_rdata;
    if (ext_cfg_req && !ext_cfg_ack) begin
      chk("ext_addr", 64'(exp_ext[50:36]), 64'({ext_cfg_wr, ext_cfg_sel, ext_cfg_addr}));
      if (ext_cfg_wr) begin
        chk("ext_wdata", 64'(exp_ext[35:0]), 64'({ext_cfg_wstrb, ext_cfg_wdata}));
      end
    end
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  function automatic logic [1:0] port_of(input logic [3:0] f);
    case (f)
      FT_MSG:   return 2'h1;
      FT_MAINT: return 2'h2;
      FT_NREAD, FT_NWRITE, FT_SWRITE, FT_RESP, FT_DBELL: return 2'h0;
      default:  return 2'h3;
    endcase
  endfunction
  // Score each transmitted beat against the prediction
  always @(posedge aclk) begin
    if (aresetn && m_axis_ttx_tvalid && m_axis_ttx_tready) begin
      et = (txq.size() != 0) ? txq.pop_front() : ~67'h0;
      chk("ttx_tdata", et[63:0], m_axis_ttx_tdata);
      chk("ttx_tlast", 64'(et[64]), 64'(m_axis_ttx_tlast));
      chk("ttx_tuser", 64'(et[63:32]), 64'(m_axis_ttx_tuser));
      chk("ttx_tkeep", 64'(KEEP_ALL), 64'(m_axis_ttx_tkeep));
    end
  end
  // Score each received beat, including which port carried it
  always @(posedge aclk) begin
    rxh = {m_axis_usrrx_tvalid & m_axis_usrrx_tready, m_axis_mntrx_tvalid & m_axis_mntrx_tready,
      m_axis_msgrx_tvalid & m_axis_msgrx_tready, m_axis_iorx_tvalid & m_axis_iorx_tready};
    rxp = rxh[3] ? 2'h3 : rxh[2] ? 2'h2 : rxh[1] ? 2'h1 : 2'h0;
    if (aresetn && rxh != 4'h0) begin
      er = (rxq.size() != 0) ? rxq.pop_front() : ~67'h0;
      chk("rx_port", 64'(er[66:65]), 64'(rxp));
      chk("rx_tdata", er[63:0], m_axis_iorx_tdata);
      chk("rx_tlast", 64'(er[64]), 64'(m_axis_iorx_tlast));
      chk("rx_tuser", 64'(er[63:32]), 64'(m_axis_iorx_tuser));
      chk("rx_tkeep", 64'(KEEP_ALL), 64'(m_axis_iorx_tkeep));
    end
  end
  task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 64'(r), 64'(s_axi_bresp));
    @(posedge aclk);
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] v, m, input logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", 64'(r), 64'(s_axi_rresp));
    chk("rdata", 64'(v), 64'(s_axi_rdata & m));
    @(posedge aclk);
  endtask
  task automatic send(input int k, input logic [3:0] ft);
    logic [63:0] w;
    logic [3:0]  b;
    w = {$random(seed), $random(seed)};
    w[55:52] = ft;
    b = 4'(($unsigned($random(seed)) % 4) + 1);
    for (int i = 0; i < b; i++) begin
      if (k == 2) rxq.push_back({port_of(ft), i == b - 1, w + 64'(i)});
      else if (k == 1 || ft != FT_MAINT) txq.push_back({2'h0, i == b - 1, w + 64'(i)});
    end
    wd[k] <= w;
    bt[k] <= b;
    st[k] <= 1'b1;
    @(posedge aclk);
    st[k] <= 1'b0;
    do @(posedge aclk); while (busy[k]);
  endtask
  task automatic drain();
    for (int i = 0; i < 300 && (txq.size() + rxq.size()) != 0; i++) @(posedge aclk);
    chk("queues_empty", 64'h0, 64'(txq.size() + rxq.size()));
  endtask
  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {aresetn, cfg_resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, st} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
    {link_width, s_axi_wstrb, exp_ext} = {2'h2, 4'hF, 1'b0, 14'h1010, 36'h0};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    cfg_resetn <= 1'b1;
    repeat (4) @(posedge aclk);
    link_width <= 2'h0;
    rd(14'(REG_CTRL), 32'h3, 32'h3, RESP_OK);
    rd(14'(REG_STAT), 32'h20, 32'hF3, RESP_OK);
    wr(14'(REG_STAT), 32'h0, RESP_SLV);
    wr(14'(REG_DROP), 32'hFFFFFFFF, RESP_OK);
    rd(14'(REG_DROP), 32'h0, 32'hFFFF, RESP_OK);
    rd(14'h00C, 32'h0, 32'h0, RESP_SLV);
    rd(14'h3000, 32'h0, 32'h0, RESP_DEC);
    wr(14'h3FFC, 32'h0, RESP_DEC);
    rd(14'h1010, EXT_WORD, 32'hFFFFFFFF, RESP_OK);
    exp_ext = {1'b1, 14'h2004, 4'hF, 32'h1};
    wr(14'h2004, 32'h1, RESP_OK);
    chk("clk_rate_sel", 64'h2, 64'(clk_rate_sel));
    foreach (io_ft[j]) send(0, io_ft[j]);
    send(0, FT_MAINT);
    send(1, FT_MAINT);
    send(1, FT_MAINT);
    for (int f = 0; f < 16; f++) send(2, 4'(f));
    drain();
    wr(14'(REG_CTRL), 32'h0, RESP_OK);
    repeat (2) @(posedge aclk);
    chk("iotx_tready", 64'h0, 64'(s_axis_iotx_tready));
    chk("trx_tready", 64'h0, 64'(s_axis_trx_tready));
    cfg_resetn <= 1'b0;
    @(posedge aclk);
    cfg_resetn <= 1'b1;
    rd(14'(REG_CTRL), 32'h3, 32'h3, RESP_OK);
    send(0, FT_NWRITE);
    drain();
    give_verdict();
  end
endmodule
`default_nettype wire
